// ==== shared/stop_recovery_pkg.sv ====
package stop_recovery_pkg;
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int RECOV_W = 8;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_RECOV = 6'h0B;
   localparam logic [5:0] IDX_CTRL = 6'h0C;
   localparam logic [5:0] IDX_STATUS = 6'h0D;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h0E;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h0F;

   // bit positions
   localparam int RECOV_FLAG_BIT = 7;
   localparam int CTRL_ENTER_STOP_BIT = 0;
   localparam int CTRL_HALT_BIT = 1;
   localparam int STATUS_STOPPED_BIT = 0;
   localparam int STATUS_DELAY_BIT = 1;
   localparam int STATUS_HALT_BIT = 2;
   localparam int IRQ_W = 2;
   localparam int IRQ_WAKE_BIT = 0;
   localparam int IRQ_STOP_BIT = 1;

   // wake sources
   typedef enum logic [2:0] {
      SRC_RESET_ONLY = 3'h0,
      SRC_PORT3_BIT0 = 3'h1,
      SRC_PORT3_BIT1 = 3'h2,
      SRC_PORT3_BIT2 = 3'h3,
      SRC_PORT3_BIT3 = 3'h4,
      SRC_PORT2_BIT7 = 3'h5,
      SRC_NOR_PORT2_LOW = 3'h6,
      SRC_NOR_PORT2_ALL = 3'h7
   } wake_src_e;

   // writable part of the recovery control register, bits 6..0
   typedef struct packed {
      logic polarity_high;
      logic por_delay;
      wake_src_e src;
      logic div2_bypass;
      logic div16;
   } recov_ctrl_s;

   localparam logic [6:0] RECOV_CTRL_RESET = 7'h20;

   // external pin group
   typedef struct packed {
      logic ext_reset_n;
      logic [7:0] port2;
      logic [3:0] port3;
   } wake_pins_s;

   localparam int PIN_W = 13;

   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_STOP = 2'h1,
      ST_DELAY = 2'h3,
      ST_RESTART = 2'h2
   } pwr_state_e;

   localparam logic [15:0] RESTART_ADDR = 16'h000C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // timing
   localparam int CLK_MHZ = 25;
   localparam int T_POR_US = 1000;
   localparam int POR_DELAY_CYCLES_DEF = T_POR_US * CLK_MHZ;
   localparam int DLY_W = 16;
   localparam int DIV_CNT_W = 5;
   localparam logic [3:0] DIV16_MASK = 4'hF;
   localparam logic [4:0] DIV32_MASK = 5'h1F;
endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync import stop_recovery_pkg::*; #(
   parameter int WIDTH = PIN_W
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pins and synchronised copy
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta_q[gi] <= 1'b1;
               sync_q[gi] <= 1'b1;
            end else begin
               meta_q[gi] <= pin_i[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   assign sync_o = sync_q;
endmodule

// ==== rtl/clock_scaler.sv ====
`timescale 1ns/1ps
module clock_scaler import stop_recovery_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // settings
   input wire logic run_i,
   input wire logic div2_bypass_i,
   input wire logic div16_i,
   // tick
   output logic tick_o
);
   logic [DIV_CNT_W-1:0] cnt_q;
   logic [DIV_CNT_W-1:0] cnt_d;
   logic tick_q;
   logic tick_d;

   // settings are used combinationally so a change acts at once
   always_comb begin
      cnt_d = run_i ? cnt_q + 5'h01 : cnt_q;
      tick_d = 1'b0;
      if (run_i) begin
         if (div16_i) begin
            tick_d = div2_bypass_i ? (cnt_q[3:0] == DIV16_MASK) : (cnt_q == DIV32_MASK); // R9
         end else begin
            tick_d = div2_bypass_i ? 1'b1 : cnt_q[0]; // R10 R12
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 5'h00;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick_o = tick_q;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_div16_gap: assert property (tick_q && div16_i && $past(div16_i) && run_i |=> !tick_q) // R9
      else $error("divide-by-16 tick not spaced");
   chk_bypass_tick: assert property (run_i && div2_bypass_i && !div16_i |=> tick_q) // R10
      else $error("undivided tick missing");
   chk_half_rate: assert property (run_i && !div2_bypass_i && !div16_i && tick_q // R10
      && !$past(div2_bypass_i) |=> !tick_q)
      else $error("divide-by-two tick too fast");
endmodule

// ==== rtl/stop_recovery_clock_control.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// [R1] control writable except bit 7; reads hide
// [R2] flag set on recovery, cleared by power-on
// [R3] flag cold after reset, warm after wake
// [R4] bit 6 picks active wake level
// [R5] bit 5 inserts reset delay after wake
// [R6] fast wake source held five input periods
// [R7] bits 4:2 pick the wake source
// [R8] software sets port3 pins digital first
// [R9] bit 0 divides clocks by sixteen
// [R10] bit 1 bypasses the divide-by-two stage
// [R11] control register sits at index 0Bh
// [R12] divider bits act at once, no reset
// [R13] every stop exit restarts at 000Ch
module stop_recovery_clock_control import stop_recovery_pkg::*; #(
   parameter int POR_DELAY_CYCLES = POR_DELAY_CYCLES_DEF
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // wake pins and reset sources
   input wire wake_pins_s pins_i,
   input wire logic wdt_timeout_i,
   // clocks and restart
   output logic osc_run_o,
   output logic core_clk_en_o,
   output logic timer_clk_en_o,
   output logic restart_o,
   output logic [15:0] restart_addr_o,
   // interrupt
   output logic irq_o
);
   localparam logic [ADDR_W-1:0] ADDR_RECOV = {IDX_RECOV, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
   localparam logic [DLY_W-1:0] DLY_LOAD = DLY_W'(POR_DELAY_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchroniser and clock scaler
   wake_pins_s pins_s;
   logic tick;
   pwr_state_e state_q;
   pwr_state_e state_d;
   recov_ctrl_s ctrl_q;
   recov_ctrl_s ctrl_d;
   logic halt_q;
   logic halt_d;

   pin_sync #(.WIDTH(PIN_W)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_i(pins_i),
      .sync_o(pins_s)
   );

   clock_scaler u_scaler (
      .aclk(aclk),
      .aresetn(aresetn),
      .run_i(state_q != ST_STOP),
      .div2_bypass_i(ctrl_q.div2_bypass),
      .div16_i(ctrl_q.div16),
      .tick_o(tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // register bus
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
   logic [DATA_W-1:0] w_data_q, w_data_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0] wr_strb;
   logic do_write, do_read, wr_lane0;
   logic flag_q;
   logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ist_set;

   assign awready = !aw_have_q && !bvalid_q;
   assign wready = !w_have_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign wr_addr = aw_have_q ? aw_addr_q : awaddr;
   assign wr_data = w_have_q ? w_data_q : wdata;
   assign wr_strb = w_have_q ? w_strb_q : wstrb;
   assign do_write = (aw_have_q || (awvalid && awready)) && (w_have_q || (wvalid && wready));
   assign do_read = arvalid && arready;
   assign wr_lane0 = do_write && wr_strb[0];

   always_comb begin
      aw_have_d = aw_have_q;
      aw_addr_d = aw_addr_q;
      w_have_d = w_have_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q && !bready;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q && !rready;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (awvalid && awready) begin
         aw_have_d = 1'b1;
         aw_addr_d = awaddr;
      end
      if (wvalid && wready) begin
         w_have_d = 1'b1;
         w_data_d = wdata;
         w_strb_d = wstrb;
      end
      if (do_write) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         unique case (wr_addr)
            ADDR_RECOV, ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STATUS, ADDR_IRQ_MASK: bresp_d = RESP_OKAY;
            default: bresp_d = RESP_SLVERR;
         endcase
      end
      if (do_read) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = '0;
         unique case (araddr)
            ADDR_RECOV: rdata_d[RECOV_FLAG_BIT] = flag_q; // R1 R11
            ADDR_CTRL: rdata_d[CTRL_HALT_BIT] = halt_q;
            ADDR_STATUS: begin
               rdata_d[STATUS_STOPPED_BIT] = (state_q == ST_STOP);
               rdata_d[STATUS_DELAY_BIT] = (state_q == ST_DELAY);
               rdata_d[STATUS_HALT_BIT] = halt_q;
            end
            ADDR_IRQ_STATUS: rdata_d[IRQ_W-1:0] = ist_q;
            ADDR_IRQ_MASK: rdata_d[IRQ_W-1:0] = imask_q;
            default: rresp_d = RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
      end else begin
         aw_have_q <= aw_have_d;
         aw_addr_q <= aw_addr_d;
         w_have_q <= w_have_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // wake source selection and sequencer
   logic src_level, src_wake, ext_wake, wdt_wake, any_wake, flag_d, enter_stop;
   logic [DLY_W-1:0] dly_q, dly_d;

   always_comb begin
      unique case (ctrl_q.src) // R7
         SRC_RESET_ONLY: src_level = 1'b0;
         SRC_PORT3_BIT0: src_level = pins_s.port3[0];
         SRC_PORT3_BIT1: src_level = pins_s.port3[1];
         SRC_PORT3_BIT2: src_level = pins_s.port3[2];
         SRC_PORT3_BIT3: src_level = pins_s.port3[3];
         SRC_PORT2_BIT7: src_level = pins_s.port2[7];
         SRC_NOR_PORT2_LOW: src_level = ~|pins_s.port2[3:0];
         SRC_NOR_PORT2_ALL: src_level = ~|pins_s.port2;
      endcase
   end

   // a source pulse shorter than the synchroniser may be missed
   assign src_wake = (ctrl_q.src != SRC_RESET_ONLY)
                     && (src_level == ctrl_q.polarity_high); // R4 R6 R7
   assign ext_wake = !pins_s.ext_reset_n;
   assign wdt_wake = wdt_timeout_i;
   assign any_wake = src_wake || ext_wake || wdt_wake;
   assign enter_stop = wr_lane0 && (wr_addr == ADDR_CTRL) && wr_data[CTRL_ENTER_STOP_BIT];

   always_comb begin
      state_d = state_q;
      dly_d = dly_q;
      flag_d = flag_q;
      ctrl_d = ctrl_q;
      halt_d = halt_q;
      if (wr_lane0 && (wr_addr == ADDR_RECOV)) begin
         ctrl_d = recov_ctrl_s'(wr_data[RECOV_W-2:0]); // R1 R11 R12
      end
      if (wr_lane0 && (wr_addr == ADDR_CTRL)) begin
         halt_d = wr_data[CTRL_HALT_BIT];
      end
      if (irq_o) begin
         halt_d = 1'b0;
      end
      unique case (state_q)
         ST_RUN: begin
            if (enter_stop) begin
               state_d = ST_STOP;
               halt_d = 1'b0;
            end
         end
         ST_STOP: begin
            if (any_wake) begin
               flag_d = src_wake && !wdt_wake && !ext_wake; // R2 R3
               dly_d = DLY_LOAD;
               state_d = ctrl_q.por_delay ? ST_DELAY : ST_RESTART; // R5
            end
         end
         ST_DELAY: begin
            if (dly_q == '0) begin
               state_d = ST_RESTART;
            end else begin
               dly_d = dly_q - 16'h0001;
            end
         end
         ST_RESTART: state_d = ST_RUN; // R13
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_RUN;
         dly_q <= '0;
         flag_q <= 1'b0; // R2 R3
         ctrl_q <= recov_ctrl_s'(RECOV_CTRL_RESET); // R4 R5 R10
         halt_q <= 1'b0;
      end else begin
         state_q <= state_d;
         dly_q <= dly_d;
         flag_q <= flag_d;
         ctrl_q <= ctrl_d;
         halt_q <= halt_d;
      end
   end

   assign osc_run_o = (state_q != ST_STOP);
   assign core_clk_en_o = tick && !halt_q && (state_q == ST_RUN); // R9 R10
   assign timer_clk_en_o = tick && (state_q == ST_RUN); // R9 R10
   assign restart_o = (state_q == ST_RESTART); // R13
   assign restart_addr_o = RESTART_ADDR; // R13

   ////////////////////////////////////////////////////////////////////////////////
   // interrupts: set wins over write-one-to-clear
   assign ist_set[IRQ_WAKE_BIT] = (state_q == ST_STOP) && any_wake;
   assign ist_set[IRQ_STOP_BIT] = (state_q == ST_RUN) && enter_stop;

   always_comb begin
      ist_d = ist_q;
      imask_d = imask_q;
      if (wr_lane0 && (wr_addr == ADDR_IRQ_STATUS)) begin
         ist_d = ist_q & ~wr_data[IRQ_W-1:0];
      end
      if (wr_lane0 && (wr_addr == ADDR_IRQ_MASK)) begin
         imask_d = wr_data[IRQ_W-1:0];
      end
      ist_d = ist_d | ist_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ist_q <= '0;
         imask_q <= '0;
      end else begin
         ist_q <= ist_d;
         imask_q <= imask_d;
      end
   end

   assign irq_o = |(ist_q & imask_q);

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_recov_read_hides: assert property (do_read && araddr == ADDR_RECOV // R1
      |=> rvalid && rdata[RECOV_FLAG_BIT-1:0] == '0 && rdata[RECOV_FLAG_BIT] == $past(flag_q))
      else $error("recovery control read shows write-only bits");
   chk_flag_warm: assert property (state_q == ST_STOP && src_wake && !wdt_wake // R2
      && !ext_wake |=> flag_q)
      else $error("warm flag not set on source wake");
   chk_flag_cold: assert property (state_q == ST_STOP && wdt_wake |=> !flag_q) // R3
      else $error("warm flag set after watchdog wake");
   chk_wake_polarity: assert property (state_q == ST_STOP && ctrl_q.src != SRC_RESET_ONLY // R4
      && src_level == ctrl_q.polarity_high |=> state_q != ST_STOP)
      else $error("selected level did not wake");
   chk_delay_select: assert property (state_q == ST_STOP && any_wake // R5
      |=> (state_q == ST_DELAY) == $past(ctrl_q.por_delay))
      else $error("reset delay choice ignored");
   chk_reset_only: assert property (state_q == ST_STOP && ctrl_q.src == SRC_RESET_ONLY // R7
      && !ext_wake && !wdt_wake |=> state_q == ST_STOP)
      else $error("port woke with reset-only source");
   chk_recov_write: assert property (wr_lane0 && wr_addr == ADDR_RECOV // R11
      |=> ctrl_q == $past(wr_data[RECOV_W-2:0]))
      else $error("recovery control write lost");
   chk_restart_end: assert property (state_q == ST_DELAY && dly_q == '0 // R13
      |=> restart_o ##1 state_q == ST_RUN && restart_addr_o == RESTART_ADDR)
      else $error("restart did not follow delay");
   chk_stop_clocks: assert property (state_q == ST_STOP |-> !core_clk_en_o && !timer_clk_en_o)
      else $error("clock enable during stop");

   cov_fast_wake: cover property (state_q == ST_STOP ##1 state_q == ST_RESTART);
   cov_slow_wake: cover property (state_q == ST_DELAY ##1 state_q == ST_RESTART);
   cov_irq: cover property ($rose(irq_o));
endmodule

// ==== bench/wake_source_model.sv ====
`timescale 1ns/1ps
module wake_source_model import stop_recovery_pkg::*; (
   // clock
   input wire logic aclk,
   // pins and reset sources toward the block
   output wake_pins_s pins_o,
   output logic wdt_timeout_o
);
   initial begin
      pins_o = {1'b1, 8'hFF, 4'hF};
      wdt_timeout_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // selected source at level lv, every other pin at the inactive level
   function automatic wake_pins_s pattern(input logic [2:0] s, input logic pol, input logic lv);
      wake_pins_s p;
      p = {1'b1, {8{~pol}}, {4{~pol}}};
      case (s)
         3'h1, 3'h2, 3'h3, 3'h4: p.port3[s - 3'h1] = lv;
         3'h5: p.port2[7] = lv;
         3'h6: p.port2[3:0] = lv ? 4'h0 : 4'hF;
         3'h7: p.port2 = lv ? 8'h00 : 8'hFF;
         default: p.ext_reset_n = 1'b1;
      endcase
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic idle(input logic [2:0] s, input logic pol);
      @(posedge aclk);
      pins_o <= pattern(s, pol, ~pol);
   endtask

   task automatic wake(input logic [2:0] s, input logic pol, input int hold);
      @(posedge aclk);
      pins_o <= pattern(s, pol, pol);
      repeat (hold) @(posedge aclk);
      pins_o <= pattern(s, pol, ~pol);
   endtask

   // ext high pulls the reset pin low, otherwise the watchdog fires
   task automatic reset_pulse(input logic ext, input int hold);
      @(posedge aclk);
      wdt_timeout_o <= ~ext;
      pins_o.ext_reset_n <= ~ext;
      repeat (hold) @(posedge aclk);
      wdt_timeout_o <= 1'b0;
      pins_o.ext_reset_n <= 1'b1;
   endtask
endmodule

// ==== bench/stop_recovery_clock_control_bench.sv ====
`timescale 1ns/1ps
module stop_recovery_clock_control_bench import stop_recovery_pkg::*;;
   localparam int DLY = 8;
   localparam logic [7:0] A_RECOV = {IDX_RECOV, 2'b00};
   localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [7:0] A_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [7:0] A_IRQ = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [7:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic osc_run, core_en, timer_en, restart, irq, wdt;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rsp;
   logic [15:0] restart_addr;
   wake_pins_s pins;
   int miscompares, samples_checked, n, t;
   int exp_ticks[4] = '{32, 2, 64, 4};

   stop_recovery_clock_control #(.POR_DELAY_CYCLES(DLY)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .pins_i(pins), .wdt_timeout_i(wdt),
      .osc_run_o(osc_run), .core_clk_en_o(core_en), .timer_clk_en_o(timer_en),
      .restart_o(restart), .restart_addr_o(restart_addr), .irq_o(irq)
   );

   wake_source_model model (.aclk(aclk), .pins_o(pins), .wdt_timeout_o(wdt));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t ns: got %0h expected %0h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic hang();
      miscompares++;
      results();
   endtask

   // bready and rready stay high for the whole run
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && k < 50);
      if (k >= 50)
         hang();
      r = bresp;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && k < 50);
      if (k >= 50)
         hang();
      d = rdata;
      r = rresp;
   endtask

   task automatic stop_and_check();
      axi_wr(A_CTRL, 32'h1, rsp);
      repeat (8) @(posedge aclk);
      chk(32'(osc_run), 32'h0);
   endtask

   task automatic wait_restart(output int cnt);
      cnt = 0;
      do begin
         @(posedge aclk);
         cnt++;
      end while (restart !== 1'b1 && cnt < 200);
      if (cnt >= 200)
         hang();
   endtask

   // core and timer ticks over a 64-cycle window, after the setting settles
   task automatic count_ticks();
      repeat (2) @(posedge aclk);
      n = 0;
      t = 0;
      repeat (64) begin
         @(posedge aclk);
         if (core_en === 1'b1)
            n++;
         if (timer_en === 1'b1)
            t++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      bready = 1'b1;
      rready = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      miscompares = 0;
      samples_checked = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // cold start; top bit ignores writes, control bits read back as zero
      axi_rd(A_RECOV, rd, rsp);
      chk(rd, 32'h0);
      axi_wr(A_RECOV, 32'hFF, rsp);
      chk(32'(rsp), 32'(RESP_OKAY));
      axi_rd(A_RECOV, rd, rsp);
      chk(rd, 32'h0);
      // divider settings changed on the fly
      for (int m = 0; m < 4; m++) begin
         axi_wr(A_RECOV, 32'(m), rsp);
         count_ticks();
         chk(32'(n), 32'(exp_ticks[m]));
         chk(32'(t), 32'(exp_ticks[m]));
      end
      // halt stops the core ticks only
      axi_wr(A_CTRL, 32'h2, rsp);
      count_ticks();
      chk(32'(n), 32'h0);
      chk(32'(t), 32'(exp_ticks[3]));
      axi_rd(A_STATUS, rd, rsp);
      chk(rd, 32'h4);
      axi_wr(A_CTRL, 32'h0, rsp);
      // every pin wake source (codes 1 to 7), alternating polarity, fast wake
      axi_wr(A_MASK, 32'h1, rsp);
      for (int s = 1; s < 8; s++) begin
         model.idle(s[2:0], s[0]);
         axi_wr(A_RECOV, {25'h0, s[0], 1'b0, s[2:0], 2'b00}, rsp);
         stop_and_check();
         fork
            model.wake(s[2:0], s[0], 5);
            wait_restart(n);
         join
         chk(32'(n <= 7), 32'h1);
         chk(32'(restart_addr), 32'h000C);
         axi_rd(A_RECOV, rd, rsp);
         chk(rd, 32'h80);
         chk(32'(irq), 32'h1);
         axi_wr(A_IRQ, 32'h3, rsp);
         chk(32'(irq), 32'h0);
      end
      // source code zero ignores pins; watchdog and reset pin wake cold
      for (int w = 0; w < 2; w++) begin
         axi_wr(A_RECOV, 32'h0, rsp);
         model.idle(3'h1, 1'b1);
         stop_and_check();
         fork
            model.reset_pulse(w[0], 5);
            wait_restart(n);
         join
         axi_rd(A_RECOV, rd, rsp);
         chk(rd, 32'h0);
      end
      // full reset delay after wake
      model.idle(3'h1, 1'b0);
      axi_wr(A_RECOV, 32'h24, rsp);
      stop_and_check();
      fork
         model.wake(3'h1, 1'b0, 5);
         wait_restart(n);
      join
      chk(32'(n >= DLY + 3 && n <= DLY + 8), 32'h1);
      axi_rd(A_RECOV, rd, rsp);
      chk(rd, 32'h80);
      // power cycle clears the warm flag
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(A_RECOV, rd, rsp);
      chk(rd, 32'h0);
      axi_rd(8'hFC, rd, rsp);
      chk(32'(rsp), 32'(RESP_SLVERR));
      chk(rd, 32'h0);
      results();
   end
endmodule
